// file: sally_port_defs.svh
// Purpose: Constants for the two-barrier entrapment lane sequencer.
// Assumes: 200 MHz system clock, seconds derived by a prescaler.
// Notes: Offsets are byte addresses on the register bus.
`ifndef SALLY_PORT_DEFS_SVH
`define SALLY_PORT_DEFS_SVH
`define CLK_HZ 200000000
`define YELLOW_S 3
`define RED_HOLD_S 1
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_CMD 8'h08
`define OFF_SECONDS 8'h0c
`define CTRL_RESET 32'h0000_0001
`define BIT_AUTO 0
`define BIT_ARMS_FITTED 1
`define BIT_ARM_BOOTH 2
`define BIT_ARM_OVERWATCH 3
`define BIT_CMD_FILL 0
`define BIT_CMD_RELEASE 1
`define SEQ_BITS 4
`endif

// file: sally_port_pkg.sv
// Purpose: Types shared by the lane sequencer.
// Assumes: Used with sally_port_defs.svh.
// Notes: One lane_out_t per lane.
package sally_port_pkg;
   typedef enum logic [3:0]
   {
      st_fill_idle = 4'h0,
      st_rel_yellow = 4'h1,
      st_rel_red = 4'h2,
      st_rel_arm1 = 4'h3,
      st_rel_bar1 = 4'h4,
      st_rel_bar2 = 4'h5,
      st_rel_arm2 = 4'h6,
      st_rel_idle = 4'h7,
      st_fil_yellow = 4'h8,
      st_fil_red = 4'h9,
      st_fil_arm2 = 4'ha,
      st_fil_bar2 = 4'hb,
      st_fil_bar1 = 4'hc,
      st_fil_arm1 = 4'hd
   } seq_state_t;

   // Signal aspect per barrier, one-hot red/yellow/green.
   typedef struct packed
   {
      logic red;
      logic yellow;
      logic green;
   } signal_t;

   // Field feedback for one lane.
   typedef struct packed
   {
      logic bar1_open;
      logic bar1_closed;
      logic bar2_open;
      logic bar2_closed;
      logic arm1_open;
      logic arm1_closed;
      logic arm2_open;
      logic arm2_closed;
      logic det1_front;
      logic det1_back;
      logic det2_front;
      logic det2_back;
   } lane_in_t;

   // Drives for one lane.
   typedef struct packed
   {
      signal_t sig1;
      signal_t sig2;
      logic bar1_open_drv;
      logic bar1_close_drv;
      logic bar2_open_drv;
      logic bar2_close_drv;
      logic arm1_open_drv;
      logic arm1_close_drv;
      logic arm2_open_drv;
      logic arm2_close_drv;
      logic fill_busy_lamp;
      logic release_busy_lamp;
      logic fill_done_lamp;
      logic release_done_lamp;
   } lane_out_t;
endpackage

// file: sally_port_barrier_sequencer.sv
// Purpose: Auto-mode sequencer for inbound and outbound entrapment lanes.
// Assumes: Field inputs synchronous to hclk; registers on AHB-Lite.
// Notes: Lane 0 is inbound, lane 1 outbound; both use one generate body.
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sally_port_defs.svh"
module sally_port_barrier_sequencer
   import sally_port_pkg::*;
#(
   parameter int unsigned CLK_HZ = `CLK_HZ,
   parameter int unsigned YELLOW_S = `YELLOW_S,
   parameter int unsigned RED_HOLD_S = `RED_HOLD_S
)
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Panel commands, index 0 inbound, 1 outbound
   input wire logic [1:0] master_fill,
   input wire logic [1:0] master_release,
   input wire logic [1:0] booth_fill,
   input wire logic [1:0] booth_release,
   input wire logic [1:0] overwatch_fill,
   input wire logic [1:0] overwatch_release,
   input wire logic [1:0] booth_armed,
   input wire logic [1:0] overwatch_armed,
   // Individual barrier switches, honoured in no mode: manual_open is unused and manual_close is masked by a constant 0
   input wire logic [1:0] manual_open,
   input wire logic [1:0] manual_close,
   // Field feedback and drives
   input wire lane_in_t [1:0] lane_in,
   output lane_out_t [1:0] lane_out
);
   localparam int unsigned SEC_CYC = CLK_HZ;
   localparam logic [31:0] SEC_LAST = 32'(SEC_CYC - 1);

   // Register file.
   logic [31:0] ctrl;
   logic [31:0] seconds;
   logic [1:0] sw_fill;
   logic [1:0] sw_release;
   logic [31:0] prescale;
   logic tick;

   // Address phase capture.
   logic ph_write;
   logic ph_read;
   logic [7:0] ph_addr;
   wire logic addr_take = hsel & hready & htrans[1];
   wire logic wr_ctrl = ph_write & (ph_addr == `OFF_CTRL);
   wire logic wr_cmd = ph_write & (ph_addr == `OFF_CMD);
   wire logic [1:0] cmd_lane = hwdata[9:8];
   wire logic auto_mode = ctrl[`BIT_AUTO];
   wire logic arms_fitted = ctrl[`BIT_ARMS_FITTED];
   seq_state_t state [2];
   wire logic [3:0] state0 = state[0];
   wire logic [3:0] state1 = state[1];
   wire logic [31:0] status_word = {24'h0, state1, state0};
   // Read selection works on the address phase, so the word is loaded at the
   // edge that takes the address and stands for the whole data phase.
   wire logic [7:0] rd_addr = {haddr[7:2], 2'b00};
   wire logic [31:0] rd_mux =
      (rd_addr == `OFF_CTRL) ? ctrl :
      (rd_addr == `OFF_STATUS) ? status_word :
      (rd_addr == `OFF_SECONDS) ? seconds : 32'h0000_0000;

   // Bus phase tracking; the slave always answers with zero wait states.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_write <= 1'b0;
         ph_read <= 1'b0;
         ph_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         ph_write <= addr_take & hwrite;
         ph_read <= addr_take & ~hwrite;
         if (addr_take)
         begin
            ph_addr <= {haddr[7:2], 2'b00};
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= (addr_take & ~hwrite) ? rd_mux : hrdata;
      end
   end

   // Control and software command registers; commands are one-cycle pulses.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= `CTRL_RESET;
         sw_fill <= 2'b00;
         sw_release <= 2'b00;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl <= {28'h0, hwdata[3:0]};
         end
         sw_fill <= (wr_cmd & hwdata[`BIT_CMD_FILL]) ? cmd_lane : 2'b00;
         sw_release <= (wr_cmd & hwdata[`BIT_CMD_RELEASE]) ? cmd_lane : 2'b00;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prescale <= 32'h0000_0000;
         tick <= 1'b0;
         seconds <= 32'h0000_0000;
      end
      else
      begin
         tick <= (prescale == SEC_LAST);
         prescale <= (prescale == SEC_LAST) ? 32'h0000_0000 : prescale + 32'h1;
         seconds <= tick ? seconds + 32'h1 : seconds;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : lane
         lane_in_t fb;
         seq_state_t next_state;
         logic [3:0] sec_cnt;
         logic arm1_ok;
         logic arm2_ok;
         logic arm1_shut;
         logic arm2_shut;
         logic det1;
         logic det2;
         logic fill_req;
         logic rel_req;
         logic want_c1;
         logic want_c2;
         logic want_o1;
         logic want_o2;
         logic want_ao1;
         logic want_ao2;
         logic want_ac1;
         logic want_ac2;
         logic g1;
         logic g2;
         logic y1;
         logic y2;
         lane_out_t q;
         assign fb = lane_in[g];
         // Missing arms count as already in place.
         assign arm1_ok = ~arms_fitted | fb.arm1_open;
         assign arm2_ok = ~arms_fitted | fb.arm2_open;
         assign arm1_shut = ~arms_fitted | fb.arm1_closed;
         assign arm2_shut = ~arms_fitted | fb.arm2_closed;
         assign det1 = fb.det1_front | fb.det1_back;
         assign det2 = fb.det2_front | fb.det2_back;
         assign fill_req = auto_mode & (master_fill[g] | sw_fill[g]
            | (booth_fill[g] & booth_armed[g]) | (overwatch_fill[g] & overwatch_armed[g]));
         assign rel_req = auto_mode & (master_release[g] | sw_release[g]
            | (booth_release[g] & booth_armed[g])
            | (overwatch_release[g] & overwatch_armed[g]));

         // Sequence step selection.
         always_comb
         begin
            next_state = state[g];
            case (state[g])
               st_fill_idle: if (rel_req) next_state = st_rel_yellow;
               st_rel_idle: if (fill_req) next_state = st_fil_yellow;
               st_rel_yellow: if (tick && sec_cnt == 4'(YELLOW_S - 1)) next_state = st_rel_red;
               st_rel_red: if (tick && sec_cnt == 4'(RED_HOLD_S - 1)) next_state = st_rel_arm1;
               st_rel_arm1: if (arm1_shut) next_state = st_rel_bar1;
               st_rel_bar1: if (fb.bar1_closed) next_state = st_rel_bar2;
               st_rel_bar2: if (fb.bar2_open) next_state = st_rel_arm2;
               st_rel_arm2: if (arm2_ok) next_state = st_rel_idle;
               st_fil_yellow: if (tick && sec_cnt == 4'(YELLOW_S - 1)) next_state = st_fil_red;
               st_fil_red: if (tick && sec_cnt == 4'(RED_HOLD_S - 1)) next_state = st_fil_arm2;
               st_fil_arm2: if (arm2_shut) next_state = st_fil_bar2;
               st_fil_bar2: if (fb.bar2_closed) next_state = st_fil_bar1;
               st_fil_bar1: if (fb.bar1_open) next_state = st_fil_arm1;
               st_fil_arm1: if (arm1_ok) next_state = st_fill_idle;
               default: next_state = st_fill_idle;
            endcase
         end

         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               state[g] <= st_fill_idle;
               sec_cnt <= 4'h0;
            end
            else
            begin
               state[g] <= next_state;
               sec_cnt <= (next_state != state[g]) ? 4'h0 : (tick ? sec_cnt + 4'h1 : sec_cnt);
            end
         end

         // Actuator intents. keeps one barrier closed: an open drive is only
         // asked while the other barrier reports fully closed.
         assign want_c1 = (state[g] == st_rel_bar1) | (~auto_mode & manual_close[0] & fb.bar2_closed & 1'b0);
         assign want_c2 = (state[g] == st_fil_bar2);
         assign want_o1 = (state[g] == st_fil_bar1) & fb.bar2_closed;
         assign want_o2 = (state[g] == st_rel_bar2) & fb.bar1_closed;
         assign want_ac1 = arms_fitted & (state[g] == st_rel_arm1);
         assign want_ac2 = arms_fitted & (state[g] == st_fil_arm2);
         assign want_ao1 = arms_fitted & (state[g] == st_fil_arm1);
         assign want_ao2 = arms_fitted & (state[g] == st_rel_arm2);
         // green needs barrier and arm open
         assign g1 = (state[g] == st_fill_idle) & fb.bar1_open & arm1_ok;
         assign g2 = (state[g] == st_rel_idle) & fb.bar2_open & arm2_ok;
         assign y1 = (state[g] == st_rel_yellow);
         assign y2 = (state[g] == st_fil_yellow);

         // Registered outputs.
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               q <= '0;
            end
            else
            begin
               q.sig1 <= '{red: ~g1 & ~y1, yellow: y1, green: g1};
               q.sig2 <= '{red: ~g2 & ~y2, yellow: y2, green: g2};
               q.bar1_close_drv <= want_c1 & ~det1;
               q.bar2_close_drv <= want_c2 & ~det2;
               q.arm1_close_drv <= want_ac1 & ~det1;
               q.arm2_close_drv <= want_ac2 & ~det2;
               q.bar1_open_drv <= want_o1;
               q.bar2_open_drv <= want_o2;
               q.arm1_open_drv <= want_ao1;
               q.arm2_open_drv <= want_ao2;
               q.fill_busy_lamp <= state[g][3];
               q.release_busy_lamp <= (state[g] != st_fill_idle) & ~state[g][3]
                  & (state[g] != st_rel_idle);
               q.fill_done_lamp <= (state[g] == st_fill_idle);
               q.release_done_lamp <= (state[g] == st_rel_idle);
            end
         end
      end
   endgenerate

   // Each lane owns its own output flops; one assignment joins them so the
   // output vector keeps a single driver.
   assign lane_out = {lane[1].q, lane[0].q};

   // Silence unused bus inputs intentionally read for width checking.
   wire logic unused_ok = &{1'b0, hsize, ph_read, manual_open};
endmodule
`default_nettype wire

// file: sally_port_barrier_sequencer_properties.sv
// Purpose: Port-level properties of the lane sequencer.
// Assumes: Field feedback levels are synchronous to hclk.
// Notes: Lane 0 carries most checks; lane 1 shares the same body.
`timescale 1ns/1ps
`default_nettype none
module sally_port_barrier_sequencer_checker
   import sally_port_pkg::*;
#(
   parameter int unsigned CLK_HZ = 200000000,
   parameter int unsigned YELLOW_S = 3,
   parameter int unsigned RED_HOLD_S = 1
)
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Field feedback and drives
   input wire lane_in_t [1:0] lane_in,
   input wire lane_out_t [1:0] lane_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   int unsigned ycnt;
   lane_in_t fi;
   lane_out_t fo;
   assign fi = lane_in[0];
   assign fo = lane_out[0];
   // Yellow dwell counter; prescaler phase may trim up to one second off the first tick.
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         ycnt <= 0;
      else
         ycnt <= fo.sig1.yellow ? ycnt + 1 : 0;
   AST_YELLOW_DWELL: assert property ($fell(fo.sig1.yellow) |->
      ycnt >= (YELLOW_S - 1) * CLK_HZ && ycnt <= YELLOW_S * CLK_HZ + 2)
      else $error("yellow dwell out of range");
   AST_RED_BEFORE_CLOSE: assert property ($rose(fo.arm1_close_drv | fo.bar1_close_drv) |->
      fo.sig1.red && $past(fo.sig1.red, 2))
      else $error("barrier 1 close without red");
   AST_BAR2_AFTER_BAR1: assert property (fo.bar2_open_drv |-> fi.bar1_closed)
      else $error("barrier 2 opens while barrier 1 not closed");
   AST_BAR1_AFTER_BAR2: assert property (fo.bar1_open_drv |-> fi.bar2_closed)
      else $error("barrier 1 opens while barrier 2 not closed");
   AST_ARM1_FIRST: assert property ($rose(fo.bar1_close_drv) |-> fi.arm1_closed)
      else $error("barrier 1 closes before its arm");
   AST_GREEN1_OPEN: assert property (fo.sig1.green |->
      $past(fi.bar1_open && fi.arm1_open))
      else $error("signal 1 green while not open");
   AST_GREEN2_OPEN: assert property (lane_out[1].sig2.green |->
      $past(lane_in[1].bar2_open && lane_in[1].arm2_open))
      else $error("outbound signal 2 green while not open");
   AST_CLOSE_SUPPRESS: assert property ($past(fi.det1_front | fi.det1_back) &&
      (fi.det1_front | fi.det1_back) |-> !fo.bar1_close_drv)
      else $error("barrier 1 close driven over a vehicle");
   AST_OPEN_HOLDS: assert property (fo.bar2_open_drv && !fi.bar2_open |=> fo.bar2_open_drv)
      else $error("barrier 2 open drive dropped early");
   AST_LAMPS: assert property (fo.fill_busy_lamp | fo.release_busy_lamp |->
      !(fo.fill_done_lamp | fo.release_done_lamp))
      else $error("busy and done lamps lit together");
   cover property ($rose(fo.sig1.yellow));
   cover property ($rose(lane_out[1].sig2.green));
   cover property (fi.det1_front && fo.sig1.red);
endmodule
bind sally_port_barrier_sequencer sally_port_barrier_sequencer_checker #(.CLK_HZ(CLK_HZ),
   .YELLOW_S(YELLOW_S), .RED_HOLD_S(RED_HOLD_S)) i_sally_port_barrier_sequencer_checker (
   .hclk(hclk), .hresetn(hresetn), .lane_in(lane_in), .lane_out(lane_out));
`default_nettype wire

// file: sally_port_field.sv
// Purpose: Behavioural barriers and arms of both lanes.
// Assumes: Position 0 is closed; travel takes 3 or 12 cycles.
// Notes: Open drive wins over close drive, as a real operator would.
`timescale 1ns/1ps
`default_nettype none
module sally_port_field
   import sally_port_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Speed select and detector levels
   input wire logic slow,
   input wire logic [1:0][3:0] det,
   // Drives in, limit switches out
   input wire lane_out_t [1:0] lane_out,
   output lane_in_t [1:0] lane_in
);
   int pos [2][4];
   int full;
   logic [1:0][3:0] opn;
   logic [1:0][3:0] cls;
   assign full = slow ? 12 : 3;
   // Drives and limit switches per lane; index 0 bar1, 1 bar2, 2 arm1, 3 arm2.
   for (genvar l = 0; l < 2; l++)
   begin : g_lane
      assign opn[l] = {lane_out[l].arm2_open_drv, lane_out[l].arm1_open_drv,
         lane_out[l].bar2_open_drv, lane_out[l].bar1_open_drv};
      assign cls[l] = {lane_out[l].arm2_close_drv, lane_out[l].arm1_close_drv,
         lane_out[l].bar2_close_drv, lane_out[l].bar1_close_drv};
      assign lane_in[l] = {pos[l][0] >= full, pos[l][0] == 0, pos[l][1] >= full,
         pos[l][1] == 0, pos[l][2] >= full, pos[l][2] == 0, pos[l][3] >= full,
         pos[l][3] == 0, det[l]};
   end
   // Travel; barrier 1 and arm 1 rest open after reset.
   always @(posedge hclk or negedge hresetn)
      for (int l = 0; l < 2; l++)
         for (int k = 0; k < 4; k++)
            if (!hresetn)
               pos[l][k] <= (k % 2 == 0) ? 12 : 0;
            else if (opn[l][k] && pos[l][k] < full)
               pos[l][k] <= pos[l][k] + 1;
            else if (cls[l][k] && pos[l][k] > 0)
               pos[l][k] <= pos[l][k] - 1;
endmodule
`default_nettype wire

// file: test_sally_port_barrier_sequencer.sv
// Purpose: Self-checking bench for the lane sequencer.
// Assumes: Seconds prescaler cut to HZ cycles; field model travels in a few cycles.
// Notes: Lane, panel, speed and detector picks come from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module test_sally_port_barrier_sequencer;
   import sally_port_pkg::*;
   localparam int unsigned HZ = 20;
   logic hclk;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic hreadyout;
   logic slow = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [5:0][1:0] cmdv = '0;
   logic [1:0] booth_armed = 2'b11;
   logic [3:0] man = 4'h0;
   logic [1:0][3:0] det = '0;
   lane_in_t [1:0] lane_in;
   lane_out_t [1:0] lane_out;
   int fails = 0;
   int n_checks = 0;
   // Design with a short seconds prescaler, and the field it drives.
   sally_port_barrier_sequencer #(.CLK_HZ(HZ)) i_sally_port_barrier_sequencer (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp(), .master_fill(cmdv[0]), .master_release(cmdv[1]),
      .booth_fill(cmdv[2]), .booth_release(cmdv[3]), .overwatch_fill(cmdv[4]),
      .overwatch_release(cmdv[5]), .booth_armed, .overwatch_armed(2'b11),
      .manual_open(man[1:0]), .manual_close(man[3:2]), .lane_in, .lane_out);
   sally_port_field i_sally_port_field (.hclk, .hresetn, .slow, .det, .lane_out, .lane_in);
   // Clock at 200 MHz.
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk)
      man <= 4'($urandom);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single word transfer; the bench waits on hready in both phases.
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      q = hrdata;
   endtask
   function automatic logic [31:0] sigs(input int l);
      return {26'h0, lane_out[l].sig1, lane_out[l].sig2};
   endfunction
   function automatic logic [31:0] lamps(input int l);
      return {28'h0, lane_out[l].fill_busy_lamp, lane_out[l].release_busy_lamp,
         lane_out[l].fill_done_lamp, lane_out[l].release_done_lamp};
   endfunction
   function automatic logic [31:0] exp_sigs(input bit r);
      return {26'h0, r ? 6'b100001 : 6'b001100};
   endfunction
   function automatic logic [31:0] exp_lamps(input bit r, input bit mv);
      return {28'h0, mv & !r, mv & r, !mv & !r, !mv & r};
   endfunction
   // Bounded wait on one lane output; a timeout counts as a mismatch.
   task automatic wait_on(input int l, input int s);
      int n;
      logic [5:0] v;
      n = 0;
      do
      begin
         @(negedge hclk);
         v = {lane_out[l].bar2_close_drv, lane_out[l].bar1_close_drv, lane_out[l].sig2.green,
            lane_out[l].sig1.green, lane_out[l].sig2.yellow, lane_out[l].sig1.yellow};
         n++;
      end
      while (v[s] !== 1'b1 && n < 3000);
      if (n >= 3000)
         chk(32'(s), 32'hff);
      @(posedge hclk);
   endtask
   // Full sequence; hold keeps a detector up and a stray command on mid-run.
   task automatic seq(input int l, input bit r, input int src, input bit hold);
      cmdv[2 * src + int'(r)][l] <= 1'b1;
      wait_on(l, r ? 0 : 1);
      cmdv <= '0;
      if (hold)
      begin
         @(posedge hclk);
         cmdv[int'(!r)][l] <= 1'b1;
         repeat (200) @(negedge hclk);
         chk(32'(lane_out[l].bar1_close_drv), 32'h0);
         @(posedge hclk);
         cmdv <= '0;
         det <= '0;
      end
      wait_on(l, r ? 4 : 5);
      @(negedge hclk);
      chk(lamps(l), exp_lamps(r, 1'b1));
      wait_on(l, r ? 3 : 2);
      repeat (3) @(negedge hclk);
      chk(sigs(l), exp_sigs(r));
      chk(lamps(l), exp_lamps(r, 1'b0));
      @(posedge hclk);
      $display("test lane %0d mode %0d done", l, r);
   endtask
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog well past the length of the eight lane sequences.
   initial
   begin
      repeat (40000) @(posedge hclk);
      fails++;
      close_out;
   end
   initial
   begin
      int lane;
      bit [1:0] st;
      logic [31:0] rd;
      void'($urandom(32'h9fa7ad43));
      st = 2'b00;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(negedge hclk);
      for (int l = 0; l < 2; l++)
      begin
         chk(sigs(l), exp_sigs(1'b0));
         chk(lamps(l), exp_lamps(1'b0, 1'b0));
      end
      @(posedge hclk);
      ahb(8'h00, 1'b1, 32'h0000_0003, rd);
      ahb(8'h00, 1'b0, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0003);
      ahb(8'h40, 1'b0, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      $display("test reset and bus done");
      booth_armed <= 2'b00;
      cmdv[3][0] <= 1'b1;
      repeat (100) @(negedge hclk);
      chk(sigs(0), exp_sigs(1'b0));
      @(posedge hclk);
      booth_armed <= 2'b11;
      cmdv <= '0;
      det[0][2 + int'($urandom % 2)] <= 1'b1;
      seq(0, 1'b1, 1, 1'b1);
      det[0][3:2] <= 2'b11;
      seq(0, 1'b0, 2, 1'b0);
      det <= '0;
      for (int i = 0; i < 6; i++)
      begin
         lane = (i == 0) ? 1 : int'($urandom % 2);
         slow <= 1'($urandom);
         seq(lane, !st[lane], int'($urandom % 3), 1'b0);
         st[lane] = !st[lane];
      end
      close_out;
   end
endmodule
`default_nettype wire
